// *** rtl/wtb_bus_if.sv ***
// Byte bus between the processor side and the timer register bank.
`timescale 1ns/10ps
interface wtb_bus_if;
	logic       wr_en;
	logic       rd_en;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport device (
		input  wr_en,
		input  rd_en,
		input  addr,
		input  wdata,
		output rdata
	);
	modport host (
		output wr_en,
		output rd_en,
		output addr,
		output wdata,
		input  rdata
	);
endinterface

// *** rtl/wtb_master.sv ***
// Processor end: turns 16-bit requests into ordered byte pairs.
`timescale 1ns/10ps
`include "wtb_params.svh"

module wtb_master
	import wtb_pkg::*;
(
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  reset_n,
	// User request
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [1:0]  req_reg,
	input  wire logic [15:0] req_wdata,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic      [15:0] rsp_rdata,
	// Byte bus
	wtb_bus_if.host    bus
);

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	// Each pair runs back to back with no gap, so nothing on this side can
	// slip a foreign access between the two bytes.
	wtb_state_t  st_ff;
	logic        write_ff;
	logic [1:0]  reg_ff;
	logic [15:0] data_ff;
	logic        rsp_ff;

	assign req_ready = (st_ff == WTB_ST_IDLE);
	wire   take      = req_valid & req_ready;

	// Write: high then low. Read: low then high.
	wire   first_hi  = write_ff;
	wire   hi_now    = (st_ff == WTB_ST_FIRST) ? first_hi : ~first_hi;
	wire   active    = (st_ff == WTB_ST_FIRST) | (st_ff == WTB_ST_SECOND);
	wire   rd_hi_cap = (st_ff == WTB_ST_DONE) & ~write_ff;

	wtb_state_t nxt_st;
	always_comb begin
		unique case (st_ff)
			WTB_ST_IDLE:   nxt_st = take ? WTB_ST_FIRST : WTB_ST_IDLE;
			WTB_ST_FIRST:  nxt_st = WTB_ST_SECOND;
			WTB_ST_SECOND: nxt_st = WTB_ST_DONE;
			WTB_ST_DONE:   nxt_st = WTB_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff    <= WTB_ST_IDLE;
			write_ff <= 1'b0;
			reg_ff   <= 2'b00;
			data_ff  <= `WTB_WORD_RST;
			rsp_ff   <= 1'b0;
		end else begin
			st_ff  <= nxt_st;
			rsp_ff <= (st_ff == WTB_ST_DONE);
			if (take) begin
				write_ff <= req_write;
				reg_ff   <= req_reg;
				data_ff  <= req_wdata;
			end else if (st_ff == WTB_ST_SECOND && !write_ff) begin
				data_ff[7:0] <= bus.rdata;
			end else if (rd_hi_cap) begin
				data_ff[15:8] <= bus.rdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Bus drive
	// ------------------------------------------------------------------------
	assign bus.wr_en = active & write_ff;
	assign bus.rd_en = active & ~write_ff;
	assign bus.addr  = {reg_ff, hi_now};
	assign bus.wdata = hi_now ? data_ff[15:8] : data_ff[7:0];
	assign rsp_valid = rsp_ff;
	assign rsp_rdata = data_ff;

endmodule

// *** rtl/wtb_params.svh ***
// Constants for the wide timer byte access block.
`ifndef WTB_PARAMS_SVH
`define WTB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Byte addresses on the 8-bit bus
// ----------------------------------------------------------------------------
`define WTB_ADDR_CNT_LO  3'h0
`define WTB_ADDR_CNT_HI  3'h1
`define WTB_ADDR_CMPA_LO 3'h2
`define WTB_ADDR_CMPA_HI 3'h3
`define WTB_ADDR_CMPB_LO 3'h4
`define WTB_ADDR_CMPB_HI 3'h5
`define WTB_ADDR_CAP_LO  3'h6
`define WTB_ADDR_CAP_HI  3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WTB_BYTE_RST     8'h00
`define WTB_WORD_RST     16'h0000

`endif

// *** rtl/wtb_pkg.sv ***
// Types shared by both ends of the wide timer byte access block.
package wtb_pkg;
	// Which 16-bit register a byte address selects.
	typedef enum logic [1:0] {
		WTB_SEL_CNT  = 2'b00,
		WTB_SEL_CMPA = 2'b01,
		WTB_SEL_CMPB = 2'b11,
		WTB_SEL_CAP  = 2'b10
	} wtb_sel_t;

	// Host sequencer states, Gray along the access path.
	typedef enum logic [1:0] {
		WTB_ST_IDLE   = 2'b00,
		WTB_ST_FIRST  = 2'b01,
		WTB_ST_SECOND = 2'b11,
		WTB_ST_DONE   = 2'b10
	} wtb_state_t;
endpackage

// *** rtl/wtb_regs.sv ***
// Timer register bank end: 16-bit registers behind an 8-bit byte bus.
`timescale 1ns/10ps
`include "wtb_params.svh"

module wtb_regs
	import wtb_pkg::*;
(
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  reset_n,
	// Processor byte bus
	wtb_bus_if.device  bus,
	// Timer core side
	input  wire logic        cnt_load_en,
	input  wire logic [15:0] cnt_next,
	input  wire logic        cap_event,
	input  wire logic [15:0] cap_in,
	output logic      [15:0] timer_count_value,
	output logic      [15:0] compare_value_a,
	output logic      [15:0] compare_value_b,
	output logic      [15:0] capture_value
);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	logic [7:0]  hold_ff;
	logic [7:0]  rdata_ff;
	logic [15:0] cnt_ff;
	logic [15:0] cmpa_ff;
	logic [15:0] cmpb_ff;
	logic [15:0] cap_ff;
	wtb_sel_t    sel;
	wire         is_low   = ~bus.addr[0];
	wire         wr_low   = bus.wr_en & is_low;
	wire         wr_high  = bus.wr_en & ~is_low;
	wire         rd_low   = bus.rd_en & is_low;
	wire         is_cmp   = (sel == WTB_SEL_CMPA) | (sel == WTB_SEL_CMPB);
	wire  [15:0] wr_word  = {hold_ff, bus.wdata};
	logic [15:0] sel_word;

	assign sel = wtb_sel_t'(bus.addr[2:1] ^ {1'b0, bus.addr[2]});

	always_comb begin
		unique case (sel)
			WTB_SEL_CNT:  sel_word = cnt_ff;
			WTB_SEL_CMPA: sel_word = cmpa_ff;
			WTB_SEL_CMPB: sel_word = cmpb_ff;
			WTB_SEL_CAP:  sel_word = cap_ff;
		endcase
	end

	// Compare high bytes come straight from the register; others from hold.
	wire [7:0] nxt_rdata = is_low ? sel_word[7:0] :
		(is_cmp ? sel_word[15:8] : hold_ff);

	// A low-byte read latches the high byte, except for compare registers.
	wire       hold_cap  = rd_low & ~is_cmp;

	// ------------------------------------------------------------------------
	// Holding register and read data
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_ff  <= `WTB_BYTE_RST;
			rdata_ff <= `WTB_BYTE_RST;
		end else begin
			if (wr_high) begin
				hold_ff <= bus.wdata;
			end else if (hold_cap) begin
				hold_ff <= sel_word[15:8];
			end
			if (bus.rd_en) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// 16-bit registers
	// ------------------------------------------------------------------------
	// A bus write to the counter wins over the timer's own update.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff  <= `WTB_WORD_RST;
			cmpa_ff <= `WTB_WORD_RST;
			cmpb_ff <= `WTB_WORD_RST;
			cap_ff  <= `WTB_WORD_RST;
		end else begin
			if (wr_low && sel == WTB_SEL_CNT) begin
				cnt_ff <= wr_word;
			end else if (cnt_load_en) begin
				cnt_ff <= cnt_next;
			end
			if (wr_low && sel == WTB_SEL_CMPA) begin
				cmpa_ff <= wr_word;
			end
			if (wr_low && sel == WTB_SEL_CMPB) begin
				cmpb_ff <= wr_word;
			end
			if (wr_low && sel == WTB_SEL_CAP) begin
				cap_ff <= wr_word;
			end else if (cap_event) begin
				cap_ff <= cap_in;
			end
		end
	end

	assign bus.rdata         = rdata_ff;
	assign timer_count_value = cnt_ff;
	assign compare_value_a   = cmpa_ff;
	assign compare_value_b   = cmpb_ff;
	assign capture_value     = cap_ff;

endmodule

// *** tb/wide_timer_register_byte_access_test.sv ***
// Self-checking test of both ends of the wide timer byte access block.
`timescale 1ns/10ps
module wide_timer_register_byte_access_test import wtb_pkg::*;;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        req_valid = 1'b0, req_write = 1'b0, load = 1'b0, cap = 1'b0;
	logic [1:0]  req_reg = 2'h0;
	logic [15:0] req_wdata = 16'h0000, cnt_next = 16'h0000, cap_in = 16'h0000;
	logic        req_ready, rsp_valid;
	logic [15:0] rsp_rdata, q;
	wire  [15:0] val [4];
	int          n_mismatch = 0, checks = 0;
	logic [15:0] w [4] = '{16'h01ff, 16'h5a3c, 16'hc381, 16'h7e42};

	wtb_bus_if bus ();
	wtb_regs i_wtb_regs (.ref_clk, .reset_n, .bus(bus.device),
		.cnt_load_en(load), .cnt_next, .cap_event(cap), .cap_in,
		.timer_count_value(val[0]), .compare_value_a(val[1]),
		.compare_value_b(val[2]), .capture_value(val[3]));
	wtb_master i_wtb_master (.ref_clk, .reset_n, .req_valid, .req_write,
		.req_reg, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
		.bus(bus.host));
	wtb_bus_properties i_wtb_bus_properties (.ref_clk, .reset_n,
		.wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
		.wdata(bus.wdata), .rdata(bus.rdata));

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Counts: %0d checks, %0d mismatches.", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// The master is idle on entry, so the request is taken at once.
	task automatic xfer(input logic wr, input int r, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_reg   <= r[1:0];
		req_wdata <= d;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 9);
		chk({15'h0000, rsp_valid}, 16'h0001);
		chk({15'h0000, req_ready}, 16'h0001);
		q = rsp_rdata;
	endtask

	initial begin
		#(25 * 2000);
		n_mismatch++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			xfer(1'b0, r, 16'h0000);
			chk(q, 16'h0000);
		end
		$display("Test reset_values done.");
		for (int r = 0; r < 4; r++) begin
			xfer(1'b1, r, w[r]);
			chk(val[r], w[r]);
		end
		for (int r = 0; r < 4; r++) begin
			xfer(1'b0, r, 16'h0000);
			chk(q, w[r]);
		end
		$display("Test write_read done.");
		@(posedge ref_clk);
		cnt_next <= 16'h3cc3;
		cap_in   <= 16'ha55a;
		load     <= 1'b1;
		cap      <= 1'b1;
		@(posedge ref_clk);
		load     <= 1'b0;
		cap      <= 1'b0;
		xfer(1'b0, 0, 16'h0000);
		chk(q, 16'h3cc3);
		xfer(1'b0, 3, 16'h0000);
		chk(q, 16'ha55a);
		xfer(1'b0, 1, 16'h0000);
		chk(q, w[1]);
		$display("Test core_update done.");
		complete_run();
	end
endmodule

// *** tb/wtb_bus_properties.sv ***
// Bus properties of the wide timer byte access block.
`timescale 1ns/10ps
module wtb_bus_properties (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       reset_n,
	// Byte bus
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	// Only bus writes change the compare words, so they can be shadowed.
	logic [7:0]  hold_ff;
	logic [15:0] cmp_ff [2];
	wire         is_cmp = addr[2] ^ addr[1];
	wire  [15:0] word = cmp_ff[addr[2]];
	wire  [7:0]  cmp_byte = addr[0] ? word[15:8] : word[7:0];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_ff <= 8'h00;
			cmp_ff  <= '{16'h0000, 16'h0000};
		end else if (wr_en && addr[0]) begin
			hold_ff <= wdata;
		end else if (wr_en && is_cmp) begin
			cmp_ff[addr[2]] <= {hold_ff, wdata};
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	property p_strobe; !(wr_en && rd_en); endproperty
	a_strobe: assert property (p_strobe)
		else $error("Both strobes high.");
	property p_cmp; rd_en && is_cmp |=> rdata == $past(cmp_byte); endproperty
	a_cmp: assert property (p_cmp)
		else $error("Compare byte read wrong.");
	property p_wpair;
		wr_en && addr[0] |=> wr_en && !addr[0]
			&& addr[2:1] == $past(addr[2:1]);
	endproperty
	a_wpair: assert property (p_wpair)
		else $error("High write not followed by low write.");
	property p_wlow; wr_en && !addr[0] |-> $past(wr_en && addr[0]); endproperty
	a_wlow: assert property (p_wlow)
		else $error("Low write without high write.");
	property p_rpair;
		rd_en && !addr[0] |=> rd_en && addr[0]
			&& addr[2:1] == $past(addr[2:1]);
	endproperty
	a_rpair: assert property (p_rpair)
		else $error("Low read not followed by high read.");
	property p_rhigh; rd_en && addr[0] |-> $past(rd_en && !addr[0]); endproperty
	a_rhigh: assert property (p_rhigh)
		else $error("High read without low read.");
	property p_gap;
		wr_en && !addr[0] || rd_en && addr[0] |=> !wr_en && !rd_en;
	endproperty
	a_gap: assert property (p_gap)
		else $error("Pair not closed by an idle cycle.");
	property p_stand; !rd_en |=> $stable(rdata); endproperty
	a_stand: assert property (p_stand)
		else $error("Read byte changed without a read.");
endmodule
